/* File: rtl/aisu_top.sv */
// Alarm interrupt enable, sticky status and phase-adjust busy registers
//
// Contract
// - Enable bits 6,4,1,0 gate lock loss, holdover, ref1 and ref0 onto the pin.
// - Any alarm sets its status bit regardless of its enable bit.
// - Status bits stay set after the alarm condition goes away.
// - A status bit clears only when the host writes one to it.
// - Status bit 6 records any lock-loss alarm since last cleared.
// - Status bit 4 records any holdover alarm since last cleared.
// - Status bits 1 and 0 record loss of signal on reference 1 and 0.
// - Busy register shows one bit per output while phase adjustment runs.
// - Interrupt pin driven low while any enabled status bit is set.
// - Reference alarm after programmed missed periods; count never below three.
`timescale 1ns/1ps
`include "aisu_params.svh"

module aisu_top
(
	// Clock, reset and enable
	input  wire logic                         clock,
	input  wire logic                         rstn,
	input  wire logic                         clk_en,
	// Register port from the serial configuration engine
	input  wire logic [`AISU_ADDR_W-1:0]      reg_addr,
	input  wire logic                         reg_wr_en,
	input  wire logic                         reg_rd_en,
	input  wire logic [`AISU_DATA_W-1:0]      reg_wdata,
	output logic      [`AISU_DATA_W-1:0]      reg_rdata,
	// PLL alarm sources
	input  wire logic                         lock_loss_alarm,
	input  wire logic                         holdover_alarm,
	// Reference monitors
	input  wire logic [`AISU_NUM_REFS-1:0]    ref_seen,
	input  wire logic                         monitor_tick,
	input  wire logic [`AISU_LOS_COUNT_W-1:0] ref0_missing_period_count,
	input  wire logic [`AISU_LOS_COUNT_W-1:0] ref1_missing_period_count,
	output logic      [`AISU_NUM_REFS-1:0]    ref_signal_loss,
	// Phase-adjust engine
	input  wire logic [`AISU_NUM_OUTPUTS-1:0] phase_adjust_in_progress,
	// Open-drain interrupt pin
	output logic                              interrupt_request_n_out,
	output logic                              interrupt_request_n_oe,
	output logic                              irq_active
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [`AISU_DATA_W-1:0]   alarm_irq_enable;
	logic [`AISU_DATA_W-1:0]   alarm_irq_status;
	logic [`AISU_DATA_W-1:0]   next_status;
	logic [`AISU_DATA_W-1:0]   set_vec;
	logic [`AISU_DATA_W-1:0]   clr_vec;
	logic [`AISU_NUM_REFS-1:0] los_alarm;
	aisu_pkg::aisu_reg_sel_t   wr_sel;
	aisu_pkg::aisu_reg_sel_t   rd_sel;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic aisu_pkg::aisu_reg_sel_t decode(input logic [`AISU_ADDR_W-1:0] addr);
		aisu_pkg::aisu_reg_sel_t sel;
		sel = aisu_pkg::aisu_sel_none;
		if (addr == `AISU_OFS_IRQ_ENABLE)
			sel = aisu_pkg::aisu_sel_enable;
		else if (addr == `AISU_OFS_IRQ_STATUS)
			sel = aisu_pkg::aisu_sel_status;
		else if (addr == `AISU_OFS_PA_BUSY)
			sel = aisu_pkg::aisu_sel_pa_busy;
		return sel;
	endfunction

	// Set takes priority so an alarm in the clearing cycle survives
	function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	assign wr_sel = decode(reg_addr);
	assign rd_sel = wr_sel;

	// ****************************************************************
	// Reference loss-of-signal monitors
	// ****************************************************************
	aisu_los_if los_link [`AISU_NUM_REFS] ();

	assign los_link[0].ref_seen     = ref_seen[0];
	assign los_link[0].monitor_tick = monitor_tick;
	assign los_link[0].limit        = ref0_missing_period_count;
	assign los_link[1].ref_seen     = ref_seen[1];
	assign los_link[1].monitor_tick = monitor_tick;
	assign los_link[1].limit        = ref1_missing_period_count;
	assign los_alarm[0]             = los_link[0].alarm;
	assign los_alarm[1]             = los_link[1].alarm;
	assign ref_signal_loss          = los_alarm;

	aisu_los_monitor u_los0
	(
		.clock  (clock),
		.rstn   (rstn),
		.clk_en (clk_en),
		.mon    (los_link[0])
	);

	aisu_los_monitor u_los1
	(
		.clock  (clock),
		.rstn   (rstn),
		.clk_en (clk_en),
		.mon    (los_link[1])
	);

	// ****************************************************************
	// Enable register
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			alarm_irq_enable <= `AISU_ENABLE_RST;
		else if (clk_en && reg_wr_en && wr_sel == aisu_pkg::aisu_sel_enable)
			alarm_irq_enable <= reg_wdata & `AISU_ALARM_MASK;
	end

	// ****************************************************************
	// Sticky status register
	// ****************************************************************
	always_comb
	begin
		set_vec                      = 8'h00;
		set_vec[`AISU_BIT_LOCK_LOSS] = lock_loss_alarm;
		set_vec[`AISU_BIT_HOLDOVER]  = holdover_alarm;
		set_vec[`AISU_BIT_REF1_LOSS] = los_alarm[1];
		set_vec[`AISU_BIT_REF0_LOSS] = los_alarm[0];
	end

	// Zeros and reserved bits in the write leave the status alone
	assign clr_vec = (reg_wr_en && wr_sel == aisu_pkg::aisu_sel_status) ?
		(reg_wdata & `AISU_ALARM_MASK) : 8'h00;

	always_comb
	begin
		next_status = 8'h00;
		for (int i = 0; i < `AISU_DATA_W; i++)
			next_status[i] = sticky_next(alarm_irq_status[i], set_vec[i], clr_vec[i]);
		next_status = next_status & `AISU_ALARM_MASK;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			alarm_irq_status <= `AISU_STATUS_RST;
		else if (clk_en)
			alarm_irq_status <= next_status;
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= `AISU_RDATA_RST;
		else if (clk_en && reg_rd_en)
		begin
			unique case (rd_sel)
				aisu_pkg::aisu_sel_enable:  reg_rdata <= alarm_irq_enable;
				aisu_pkg::aisu_sel_status:  reg_rdata <= alarm_irq_status;
				aisu_pkg::aisu_sel_pa_busy: reg_rdata <= phase_adjust_in_progress;
				aisu_pkg::aisu_sel_none:    reg_rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Interrupt pin
	// ****************************************************************
	// Open drain: only ever pulls low, released by dropping the enable
	assign irq_active              = |(alarm_irq_status & alarm_irq_enable);
	assign interrupt_request_n_out = 1'b0;
	assign interrupt_request_n_oe  = irq_active;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence s_lock_loss_event;
		clk_en && lock_loss_alarm;
	endsequence

	sequence s_hold_with_enable;
		clk_en && holdover_alarm && alarm_irq_enable[`AISU_BIT_HOLDOVER] &&
			!(reg_wr_en && wr_sel == aisu_pkg::aisu_sel_enable);
	endsequence

	sequence s_ref0_set_and_clear;
		clk_en && los_alarm[0] && clr_vec[`AISU_BIT_REF0_LOSS];
	endsequence

	sequence s_lock_flag_held;
		clk_en && alarm_irq_status[`AISU_BIT_LOCK_LOSS] && !clr_vec[`AISU_BIT_LOCK_LOSS];
	endsequence

	AST_ALARM_SETS_FLAG: assert property (s_lock_loss_event |=>
		alarm_irq_status[`AISU_BIT_LOCK_LOSS])
		else $error("lock-loss alarm did not set its status bit");

	AST_FLAG_STICKY: assert property (s_lock_flag_held |=>
		alarm_irq_status[`AISU_BIT_LOCK_LOSS])
		else $error("status bit dropped without a clearing write");

	AST_CLEAR_ONLY_BY_ONE: assert property (clk_en |=>
		((($past(alarm_irq_status) & ~$past(clr_vec)) & ~alarm_irq_status) == 8'h00))
		else $error("status bit cleared without a one written to it");

	AST_CLEAR_TAKES: assert property (clk_en && clr_vec[`AISU_BIT_HOLDOVER] && !holdover_alarm |=>
		!alarm_irq_status[`AISU_BIT_HOLDOVER])
		else $error("write of one did not clear holdover status");

	AST_SET_BEATS_CLEAR: assert property (s_ref0_set_and_clear |=>
		alarm_irq_status[`AISU_BIT_REF0_LOSS])
		else $error("alarm lost in the clearing cycle");

	AST_REF1_FLAG: assert property (clk_en && los_alarm[1] |=>
		alarm_irq_status[`AISU_BIT_REF1_LOSS] ##1 1'b1)
		else $error("reference 1 loss did not set its status bit");

	AST_IRQ_FOLLOWS: assert property (s_hold_with_enable |=> interrupt_request_n_oe)
		else $error("enabled alarm did not pull the interrupt pin");

	AST_MASKED_QUIET: assert property (alarm_irq_enable == 8'h00 |->
		!interrupt_request_n_oe && !irq_active)
		else $error("interrupt pin pulled with all enables clear");

	AST_RESERVED_ZERO: assert property (((alarm_irq_status | alarm_irq_enable) &
		~`AISU_ALARM_MASK) == 8'h00)
		else $error("reserved status or enable bit set");

	AST_BUSY_READ: assert property (clk_en && reg_rd_en && rd_sel == aisu_pkg::aisu_sel_pa_busy |=>
		reg_rdata == $past(phase_adjust_in_progress))
		else $error("busy read does not match phase-adjust state");

	AST_RESET_CLEAN: assert property (@(posedge clock) disable iff (1'b0)
		!rstn |-> alarm_irq_status == 8'h00 && alarm_irq_enable == 8'h00 && !interrupt_request_n_oe)
		else $error("state not cleared under reset");

	// ****************************************************************
	// Register port and pin checks
	// ****************************************************************
	sequence s_enable_write;
		clk_en && reg_wr_en && wr_sel == aisu_pkg::aisu_sel_enable;
	endsequence

	sequence s_status_zero_write;
		clk_en && reg_wr_en && wr_sel == aisu_pkg::aisu_sel_status && reg_wdata == 8'h00;
	endsequence

	// Masked alarm with nothing else pending must leave the pin alone
	sequence s_hold_masked;
		clk_en && holdover_alarm && !alarm_irq_enable[`AISU_BIT_HOLDOVER] && !reg_wr_en &&
			(alarm_irq_status & alarm_irq_enable) == 8'h00;
	endsequence

	AST_HOLD_SETS_FLAG: assert property (clk_en && holdover_alarm |=>
		alarm_irq_status[`AISU_BIT_HOLDOVER])
		else $error("holdover alarm did not set its status bit");

	AST_REF0_FLAG: assert property (clk_en && los_alarm[0] |=>
		alarm_irq_status[`AISU_BIT_REF0_LOSS])
		else $error("reference 0 loss did not set its status bit");

	AST_MASKED_ALARM_QUIET: assert property (s_hold_masked |=>
		!interrupt_request_n_oe)
		else $error("masked holdover alarm pulled the interrupt pin");

	AST_LOCK_PULLS_PIN: assert property (clk_en && lock_loss_alarm && !reg_wr_en &&
		alarm_irq_enable[`AISU_BIT_LOCK_LOSS] |=> interrupt_request_n_oe)
		else $error("enabled lock-loss alarm did not pull the interrupt pin");

	AST_ZERO_WRITE_KEEPS: assert property (s_status_zero_write |=>
		(($past(alarm_irq_status) & ~alarm_irq_status) == 8'h00))
		else $error("writing zero changed a status bit");

	AST_ENABLE_WRITE: assert property (s_enable_write |=>
		alarm_irq_enable == ($past(reg_wdata) & `AISU_ALARM_MASK))
		else $error("enable write did not land");

	AST_ENABLE_HOLDS: assert property (!(clk_en && reg_wr_en && wr_sel == aisu_pkg::aisu_sel_enable)
		|=> $stable(alarm_irq_enable))
		else $error("enable register changed without a write");

	AST_FROZEN: assert property (!clk_en |=> $stable(alarm_irq_status) &&
		$stable(alarm_irq_enable) && $stable(reg_rdata))
		else $error("state moved while the clock enable was low");

	AST_RDATA_HOLDS: assert property (!(clk_en && reg_rd_en) |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	AST_IRQ_RELEASED: assert property (clk_en && set_vec == 8'h00 && alarm_irq_status != 8'h00 &&
		clr_vec == alarm_irq_status |=> !interrupt_request_n_oe)
		else $error("interrupt pin held after every flag was cleared");

	AST_LOS_CLEARS: assert property (clk_en |=>
		(($past(ref_seen) & los_alarm) == 2'b00))
		else $error("reference alarm stayed up after the reference was seen");

endmodule // aisu_top

/* File: rtl/aisu_params.svh */
// Register offsets, field positions, reset values and timing counts of the alarm unit
`ifndef AISU_PARAMS_SVH
`define AISU_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define AISU_ADDR_W            16
`define AISU_DATA_W            8
`define AISU_OFS_IRQ_ENABLE    16'h00C7
`define AISU_OFS_RSVD_ENABLE   16'h00C8
`define AISU_OFS_IRQ_STATUS    16'h0200
`define AISU_OFS_RSVD_STAT_A   16'h0201
`define AISU_OFS_RSVD_STAT_B   16'h0202
`define AISU_OFS_RSVD_STAT_C   16'h0203
`define AISU_OFS_PA_BUSY       16'h0204

// ****************************************************************
// Field positions
// ****************************************************************
`define AISU_BIT_LOCK_LOSS     6
`define AISU_BIT_HOLDOVER      4
`define AISU_BIT_REF1_LOSS     1
`define AISU_BIT_REF0_LOSS     0
`define AISU_ALARM_MASK        8'h53

// ****************************************************************
// Reset values
// ****************************************************************
`define AISU_ENABLE_RST        8'h00
`define AISU_STATUS_RST        8'h00
`define AISU_RDATA_RST         8'h00

// ****************************************************************
// Loss-of-signal monitor counts
// ****************************************************************
`define AISU_LOS_COUNT_W       17
`define AISU_LOS_MIN_COUNT     17'h00003
`define AISU_NUM_REFS          2
`define AISU_NUM_OUTPUTS       8

`endif

/* File: rtl/aisu_pkg.sv */
// Types shared by the alarm interrupt status unit
package aisu_pkg;

	// ****************************************************************
	// Loss-of-signal monitor states
	// ****************************************************************
	typedef enum logic [1:0] {
		aisu_mon_watch = 2'b00,
		aisu_mon_lost  = 2'b01
	} aisu_mon_state_t;

	// ****************************************************************
	// Register decode result
	// ****************************************************************
	typedef enum logic [1:0] {
		aisu_sel_none    = 2'b00,
		aisu_sel_enable  = 2'b01,
		aisu_sel_status  = 2'b10,
		aisu_sel_pa_busy = 2'b11
	} aisu_reg_sel_t;

endpackage

/* File: rtl/aisu_los_if.sv */
// Interface between the alarm unit and one reference loss-of-signal monitor
`timescale 1ns/1ps
`include "aisu_params.svh"

interface aisu_los_if;
	logic                         ref_seen;
	logic                         monitor_tick;
	logic [`AISU_LOS_COUNT_W-1:0] limit;
	logic                         alarm;

	modport monitor (
		input  ref_seen,
		input  monitor_tick,
		input  limit,
		output alarm
	);

	modport owner (
		output ref_seen,
		output monitor_tick,
		output limit,
		input  alarm
	);
endinterface

/* File: rtl/aisu_los_monitor.sv */
// Loss-of-signal monitor for one input reference
`timescale 1ns/1ps
`include "aisu_params.svh"

module aisu_los_monitor
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// Monitor link
	aisu_los_if.monitor      mon
);

	aisu_pkg::aisu_mon_state_t    state;
	logic [`AISU_LOS_COUNT_W-1:0] missed;
	logic [`AISU_LOS_COUNT_W-1:0] eff_limit;
	logic                         reached;

	// Settings below the floor would flag a healthy reference
	assign eff_limit = (mon.limit < `AISU_LOS_MIN_COUNT) ? `AISU_LOS_MIN_COUNT : mon.limit;
	assign reached   = mon.monitor_tick && (missed + 17'h00001 >= eff_limit);

	// ****************************************************************
	// Missed-period counter
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			missed <= 17'h00000;
		else if (clk_en)
		begin
			if (mon.ref_seen)
				missed <= 17'h00000;
			else if (mon.monitor_tick && missed != 17'h1FFFF)
				missed <= missed + 17'h00001;
		end
	end

	// ****************************************************************
	// Alarm state
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			state <= aisu_pkg::aisu_mon_watch;
		else if (clk_en)
		begin
			unique case (state)
				aisu_pkg::aisu_mon_watch:
					if (!mon.ref_seen && reached)
						state <= aisu_pkg::aisu_mon_lost;
				aisu_pkg::aisu_mon_lost:
					if (mon.ref_seen)
						state <= aisu_pkg::aisu_mon_watch;
				default:
					state <= aisu_pkg::aisu_mon_watch;
			endcase
		end
	end

	assign mon.alarm = (state == aisu_pkg::aisu_mon_lost);

	AST_LOS_NOT_EARLY: assert property (@(posedge clock) disable iff (!rstn)
		$rose(mon.alarm) |-> $past(missed) + 17'h00001 >= `AISU_LOS_MIN_COUNT)
		else $error("reference alarm raised before three missed periods");

endmodule // aisu_los_monitor

/* File: testbench/aisu_host_model.sv */
// Host model that drives the register port of the alarm unit
`timescale 1ns/1ps
`include "aisu_params.svh"

module aisu_host_model
(
	// Clock
	input  wire logic                    clock,
	// Register port
	output logic [`AISU_ADDR_W-1:0]      reg_addr,
	output logic                         reg_wr_en,
	output logic                         reg_rd_en,
	output logic [`AISU_DATA_W-1:0]      reg_wdata,
	input  wire logic [`AISU_DATA_W-1:0] reg_rdata
);
	initial
	begin
		reg_addr  = 16'h0000;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
	end

	// ****************************************************************
	// Bus cycles, launched on the falling edge
	// ****************************************************************
	task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
		@(negedge clock);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_wr_en <= 1'b1;
		@(negedge clock);
		reg_wr_en <= 1'b0;
		// Released data must not look like the last value
		reg_wdata <= ~data;
	endtask

	task automatic read_reg(input logic [15:0] addr, output logic [7:0] data);
		@(negedge clock);
		reg_addr  <= addr;
		reg_rd_en <= 1'b1;
		@(negedge clock);
		reg_rd_en <= 1'b0;
		data = reg_rdata;
	endtask

	// Clears only the named live flags; reserved bits written as zero
	task automatic clear_status(input logic [7:0] flags);
		write_reg(`AISU_OFS_IRQ_STATUS, flags & `AISU_ALARM_MASK);
	endtask

	// No phase-adjust start exists on this port, so busy outputs are never disturbed
endmodule // aisu_host_model

/* File: testbench/tb.sv */
// Self-checking bench for the alarm interrupt status unit
`timescale 1ns/1ps
`include "aisu_params.svh"

module tb;
	typedef struct packed
	{
		logic [1:0] src;
		logic [7:0] en;
		logic [7:0] stat;
		logic       irq;
	} aisu_row_t;

	logic        clock;
	logic        rstn;
	logic        clk_en;
	logic [15:0] reg_addr;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        lock_loss_alarm;
	logic        holdover_alarm;
	logic [1:0]  ref_seen;
	logic        monitor_tick;
	logic [16:0] limit0;
	logic [16:0] limit1;
	logic [1:0]  ref_signal_loss;
	logic [7:0]  pa_busy;
	logic        irq_n_out;
	logic        irq_n_oe;
	logic        irq_active;
	logic [7:0]  rd;
	int          mismatches;
	int          tests_run;

	// Source: 0 lock loss, 1 holdover, 2 ref1 loss, 3 ref0 loss
	aisu_row_t rows [7] = '{
		'{2'h0, 8'h40, 8'h40, 1'b1}, '{2'h0, 8'h00, 8'h40, 1'b0},
		'{2'h1, 8'h10, 8'h10, 1'b1}, '{2'h1, 8'h40, 8'h10, 1'b0},
		'{2'h2, 8'h02, 8'h02, 1'b1}, '{2'h3, 8'h01, 8'h01, 1'b1},
		'{2'h3, 8'h02, 8'h01, 1'b0}};

	aisu_top DUT (.clock(clock), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .lock_loss_alarm(lock_loss_alarm),
		.holdover_alarm(holdover_alarm), .ref_seen(ref_seen), .monitor_tick(monitor_tick),
		.ref0_missing_period_count(limit0), .ref1_missing_period_count(limit1),
		.ref_signal_loss(ref_signal_loss), .phase_adjust_in_progress(pa_busy),
		.interrupt_request_n_out(irq_n_out), .interrupt_request_n_oe(irq_n_oe),
		.irq_active(irq_active));

	aisu_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	initial
		clock = 1'b0;
	always #5 clock = ~clock;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic pulse_seen(input logic [1:0] which);
		@(negedge clock);
		ref_seen = which;
		@(negedge clock);
		ref_seen = 2'b00;
	endtask

	// Keep names the references that still show edges during the ticks
	task automatic tick_ref(input int n, input logic [1:0] keep);
		repeat (n)
		begin
			@(negedge clock);
			monitor_tick = 1'b1;
			ref_seen     = keep;
			@(negedge clock);
			monitor_tick = 1'b0;
			ref_seen     = 2'b00;
		end
	endtask

	task automatic raise(input logic [1:0] src);
		if (src < 2'h2)
		begin
			@(negedge clock);
			lock_loss_alarm = (src == 2'h0);
			holdover_alarm  = (src == 2'h1);
			@(negedge clock);
			lock_loss_alarm = 1'b0;
			holdover_alarm  = 1'b0;
		end
		else
		begin
			pulse_seen(2'b11);
			// Ref1 limit is 4, ref0 limit 0 acts as 3; the other reference stays alive
			if (src == 2'h2)
				tick_ref(4, 2'b01);
			else
				tick_ref(3, 2'b10);
			repeat (3) @(negedge clock);
			// Alarm condition goes away; the flag must stay
			pulse_seen(2'b11);
		end
	endtask

	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		mismatches = 0;
		tests_run = 0;
		rstn = 1'b0;
		clk_en = 1'b1;
		lock_loss_alarm = 1'b0;
		holdover_alarm = 1'b0;
		ref_seen = 2'b00;
		monitor_tick = 1'b0;
		limit0 = 17'h00000;
		limit1 = 17'h00004;
		pa_busy = 8'h00;
		repeat (10) @(negedge clock);
		rstn = 1'b1;
		check(irq_n_oe, 1'b0);
		host.read_reg(`AISU_OFS_IRQ_ENABLE, rd);
		check(rd, 8'h00);
		host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
		check(rd, 8'h00);
		$display("Test reset done");

		foreach (rows[i])
		begin
			host.write_reg(`AISU_OFS_IRQ_ENABLE, rows[i].en);
			raise(rows[i].src);
			repeat (5) @(negedge clock);
			host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
			check(rd, rows[i].stat);
			check(irq_active, rows[i].irq);
			check(irq_n_oe, rows[i].irq);
			check(irq_n_out, 1'b0);
			host.write_reg(`AISU_OFS_IRQ_STATUS, 8'h00);
			host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
			check(rd, rows[i].stat);
			host.clear_status(rows[i].stat);
			host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
			check(rd, 8'h00);
			check(irq_n_oe, 1'b0);
		end
		$display("Test alarm table done");

		pulse_seen(2'b11);
		tick_ref(2, 2'b00);
		@(negedge clock);
		check(ref_signal_loss, 2'b00);
		tick_ref(1, 2'b00);
		@(negedge clock);
		check(ref_signal_loss, 2'b01);
		tick_ref(1, 2'b00);
		@(negedge clock);
		check(ref_signal_loss, 2'b11);
		pulse_seen(2'b11);
		@(negedge clock);
		check(ref_signal_loss, 2'b00);
		host.clear_status(8'h03);
		$display("Test loss threshold done");

		host.write_reg(`AISU_OFS_IRQ_ENABLE, 8'hFF);
		host.read_reg(`AISU_OFS_IRQ_ENABLE, rd);
		check(rd, 8'h53);
		host.write_reg(`AISU_OFS_RSVD_ENABLE, 8'hFF);
		host.read_reg(`AISU_OFS_RSVD_ENABLE, rd);
		check(rd, 8'h00);
		for (int a = 1; a < 4; a++)
		begin
			host.read_reg(`AISU_OFS_IRQ_STATUS + a[15:0], rd);
			check(rd, 8'h00);
		end
		foreach (rows[i])
		begin
			pa_busy = {rows[i].en[3:0], rows[i].stat[7:4]} ^ 8'hA5;
			host.write_reg(`AISU_OFS_PA_BUSY, ~pa_busy);
			host.read_reg(`AISU_OFS_PA_BUSY, rd);
			check(rd, {rows[i].en[3:0], rows[i].stat[7:4]} ^ 8'hA5);
		end
		$display("Test reserved and busy done");

		fork
			host.write_reg(`AISU_OFS_IRQ_STATUS, 8'h40);
			begin
				@(negedge clock);
				@(negedge clock);
				lock_loss_alarm = 1'b0;
			end
			begin
				@(negedge clock);
				lock_loss_alarm = 1'b1;
			end
		join
		host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
		check(rd, 8'h40);
		// Ref0 stays lost while its flag is cleared, so the flag must survive
		tick_ref(3, 2'b10);
		@(negedge clock);
		check(ref_signal_loss, 2'b01);
		host.clear_status(8'h01);
		host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
		check(rd, 8'h41);
		pulse_seen(2'b11);
		host.clear_status(8'h01);
		host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
		check(rd, 8'h40);
		@(negedge clock);
		clk_en = 1'b0;
		raise(2'h1);
		clk_en = 1'b1;
		host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
		check(rd, 8'h40);
		$display("Test set wins done");

		check(irq_n_oe, 1'b1);
		@(negedge clock);
		rstn = 1'b0;
		#1;
		check(irq_n_oe, 1'b0);
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		host.read_reg(`AISU_OFS_IRQ_ENABLE, rd);
		check(rd, 8'h00);
		host.read_reg(`AISU_OFS_IRQ_STATUS, rd);
		check(rd, 8'h00);
		$display("Test mid-run reset done");
		tally_and_finish();
	end
endmodule // tb
